// ---- logic/msr_pkg.sv ----
package msr_pkg;

  // command codes
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] CMD_START = 8'h01;
  localparam logic [7:0] CMD_INDEX_ARM = 8'h03;
  localparam logic [7:0] CMD_FILTER_UPDATE = 8'h04;
  localparam logic [7:0] CMD_NARROW_OUT = 8'h05;
  localparam logic [7:0] CMD_WIDE_OUT = 8'h06;
  localparam logic [7:0] CMD_DES_VEL_READ = 8'h07;
  localparam logic [7:0] CMD_DES_POS_READ = 8'h08;
  localparam logic [7:0] CMD_IDX_POS_READ = 8'h09;
  localparam logic [7:0] CMD_ACT_POS_READ = 8'h0a;
  localparam logic [7:0] CMD_ACT_VEL_READ = 8'h0b;
  localparam logic [7:0] CMD_SIGNALS_READ = 8'h0c;
  localparam logic [7:0] CMD_ERR_STOP_LOAD = 8'h1a;
  localparam logic [7:0] CMD_ERR_IRQ_LOAD = 8'h1b;
  localparam logic [7:0] CMD_IRQ_CLEAR = 8'h1d;
  localparam logic [7:0] CMD_TRAJ_LOAD = 8'h1f;
  localparam logic [7:0] CMD_BP_ABS_LOAD = 8'h20;
  localparam logic [7:0] CMD_BP_REL_LOAD = 8'h21;

  // status byte bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_CMD_ERR = 1;
  localparam int ST_TRAJ_DONE = 2;
  localparam int ST_INDEX = 3;
  localparam int ST_WRAP = 4;
  localparam int ST_POS_ERR = 5;
  localparam int ST_BREAKPOINT = 6;
  localparam int ST_MOTOR_OFF = 7;

  // trajectory control word bit positions
  localparam int TW_ACCEL_LOAD = 5;
  localparam int TW_MOTOR_OFF = 8;
  localparam int TW_VEL_MODE = 11;
  localparam int TW_FORWARD = 12;

  // byte counts of read-backs, minus one
  localparam logic [1:0] LEN_TWO = 2'h1;
  localparam logic [1:0] LEN_FOUR = 2'h3;

  // busy time after each accepted host byte
  localparam int BUSY_TIME_NS = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam logic [3:0] BUSY_CYCLES = 4'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // reset values
  localparam logic [7:0] DOUT_RESET = 8'h00;
  localparam logic [15:0] TRAJ_WORD_RESET = 16'h0000;

  typedef enum logic [2:0] {
    MSR_IDLE = 3'b001,
    MSR_READ = 3'b010,
    MSR_WRITE = 3'b100
  } msr_mode_type;

endpackage : msr_pkg

// ---- logic/msr_readback.sv ----
`timescale 1ns/1ps
module msr_readback (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host port pins
  input wire logic cs_n,
  input wire logic port_select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  output logic host_irq,
  // motion core events
  input wire logic core_busy,
  input wire logic breakpoint_hit,
  input wire logic pos_error_exceeded,
  input wire logic wraparound,
  input wire logic index_pulse,
  input wire logic traj_finished,
  input wire logic sample_tick,
  input wire logic [5:0] irq_mask,
  // motion core values
  input wire logic [31:0] desired_position,
  input wire logic [31:0] actual_position,
  input wire logic [31:0] desired_velocity,
  input wire logic [15:0] actual_velocity,
  // drive state
  output logic motor_off
);

  logic [11:0] sync1;
  logic [11:0] sync2;
  logic rd_prev;
  logic wr_prev;
  logic wr_ps_n;
  logic next_wr_ps_n;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;
  logic rd_ps_n;
  logic next_rd_ps_n;
  logic rd_counts;
  logic next_rd_counts;
  logic [7:0] next_data_out;
  logic next_data_oe;
  logic next_host_irq;
  logic next_motor_off;
  msr_pkg::msr_mode_type mode;
  msr_pkg::msr_mode_type next_mode;
  logic [7:0] cmd;
  logic [7:0] next_cmd;
  logic [1:0] byte_idx;
  logic [1:0] next_byte_idx;
  logic [3:0] busy_cnt;
  logic [3:0] next_busy_cnt;
  logic [15:0] traj_word;
  logic [15:0] next_traj_word;
  logic [6:1] flags;
  logic [6:1] next_flags;
  logic accel_loaded;
  logic next_accel_loaded;
  logic filter_pending;
  logic next_filter_pending;
  logic forward_dir;
  logic next_forward_dir;
  logic vel_mode;
  logic next_vel_mode;
  logic on_target;
  logic next_on_target;
  logic stop_on_error;
  logic next_stop_on_error;
  logic narrow_out;
  logic next_narrow_out;
  logic index_armed;
  logic next_index_armed;
  logic done_prev;
  logic next_done_prev;
  logic [31:0] index_position;
  logic [31:0] next_index_position;

  logic cs_s;
  logic ps_s;
  logic rd_s;
  logic wr_s;
  logic [7:0] din_s;
  logic rd_act;
  logic wr_act;
  logic busy;
  logic [7:0] status_byte;
  logic [15:0] signals_word;
  logic [31:0] read_word;
  logic [1:0] read_len;
  logic [1:0] byte_sel;
  logic [7:0] read_byte;
  logic [6:1] events;
  logic done_cond;

  // first stage feeds only the second
  assign {cs_s, ps_s, rd_s, wr_s, din_s} = sync2;
  assign rd_act = ~cs_s & ~rd_s;
  assign wr_act = ~cs_s & ~wr_s;
  assign busy = (busy_cnt != 4'h0) | core_busy;
  assign done_cond = motor_off | on_target;

  always_comb begin
    status_byte = {motor_off, flags, busy};
    signals_word = {host_irq, accel_loaded, filter_pending, forward_dir, vel_mode, on_target,
                    stop_on_error, narrow_out, status_byte[7:1], index_armed};
    read_word = 32'h0000_0000;
    read_len = msr_pkg::LEN_FOUR;
    unique case (cmd)
      msr_pkg::CMD_SIGNALS_READ: begin
        read_word = {16'h0000, signals_word};
        read_len = msr_pkg::LEN_TWO;
      end
      msr_pkg::CMD_IDX_POS_READ: read_word = index_position;
      msr_pkg::CMD_DES_POS_READ: read_word = desired_position;
      msr_pkg::CMD_ACT_POS_READ: read_word = actual_position;
      msr_pkg::CMD_DES_VEL_READ: read_word = desired_velocity;
      msr_pkg::CMD_ACT_VEL_READ: begin
        read_word = {16'h0000, actual_velocity};
        read_len = msr_pkg::LEN_TWO;
      end
      default: read_word = 32'h0000_0000;
    endcase
    byte_sel = read_len - byte_idx; // most significant byte first
    read_byte = read_word[{byte_sel, 3'b000} +: 8];
  end

  always_comb begin
    next_wr_ps_n = wr_ps_n;
    next_wr_data = wr_data;
    next_rd_ps_n = rd_ps_n;
    next_rd_counts = rd_counts;
    next_data_out = data_out;
    next_data_oe = data_oe;
    next_mode = mode;
    next_cmd = cmd;
    next_byte_idx = byte_idx;
    next_busy_cnt = (busy_cnt != 4'h0) ? busy_cnt - 4'h1 : 4'h0;
    next_traj_word = traj_word;
    next_accel_loaded = accel_loaded;
    next_filter_pending = filter_pending;
    next_forward_dir = forward_dir;
    next_vel_mode = vel_mode;
    next_on_target = on_target;
    next_stop_on_error = stop_on_error;
    next_narrow_out = narrow_out;
    next_index_armed = index_armed;
    next_index_position = index_position;
    next_motor_off = motor_off;
    next_done_prev = done_cond;
    events = 6'h00;
    // hold latest levels while the write strobe is low
    if (wr_act) begin
      next_wr_ps_n = ps_s;
      next_wr_data = din_s;
    end
    if (rd_act & ~rd_prev) begin
      next_data_oe = 1'b1;
      next_rd_ps_n = ps_s;
      next_rd_counts = 1'b0;
      if (!ps_s) begin
        next_data_out = status_byte;
      end else if (busy) begin
        next_data_out = data_out;
      end else if (mode == msr_pkg::MSR_READ) begin
        next_data_out = read_byte;
        next_rd_counts = 1'b1;
      end else begin
        events[msr_pkg::ST_CMD_ERR] = (mode == msr_pkg::MSR_WRITE);
      end
    end
    if (~rd_act & rd_prev) begin
      next_data_oe = 1'b0;
      if (rd_ps_n && rd_counts) begin
        next_byte_idx = byte_idx + 2'h1;
        next_busy_cnt = msr_pkg::BUSY_CYCLES;
      end
    end
    // busy host writes are dropped without error
    if (~wr_act & wr_prev & ~busy) begin
      next_busy_cnt = msr_pkg::BUSY_CYCLES;
      if (!wr_ps_n) begin
        next_cmd = wr_data;
        next_byte_idx = 2'h0;
        next_mode = msr_pkg::MSR_IDLE;
        unique case (wr_data)
          msr_pkg::CMD_SIGNALS_READ, msr_pkg::CMD_IDX_POS_READ, msr_pkg::CMD_DES_POS_READ,
          msr_pkg::CMD_ACT_POS_READ, msr_pkg::CMD_DES_VEL_READ,
          msr_pkg::CMD_ACT_VEL_READ: next_mode = msr_pkg::MSR_READ;
          msr_pkg::CMD_TRAJ_LOAD, msr_pkg::CMD_BP_ABS_LOAD,
          msr_pkg::CMD_BP_REL_LOAD: next_mode = msr_pkg::MSR_WRITE;
          msr_pkg::CMD_ERR_STOP_LOAD: begin
            next_mode = msr_pkg::MSR_WRITE;
            next_stop_on_error = 1'b1;
          end
          msr_pkg::CMD_ERR_IRQ_LOAD: begin
            next_mode = msr_pkg::MSR_WRITE;
            next_stop_on_error = 1'b0;
          end
          msr_pkg::CMD_RESET: begin
            next_motor_off = 1'b1;
            next_narrow_out = 1'b1;
          end
          msr_pkg::CMD_START: begin
            next_motor_off = traj_word[msr_pkg::TW_MOTOR_OFF];
            next_forward_dir = traj_word[msr_pkg::TW_FORWARD];
            next_vel_mode = traj_word[msr_pkg::TW_VEL_MODE];
            next_accel_loaded = 1'b0;
            next_on_target = 1'b0;
          end
          msr_pkg::CMD_INDEX_ARM: next_index_armed = 1'b1;
          msr_pkg::CMD_FILTER_UPDATE: next_filter_pending = 1'b1;
          msr_pkg::CMD_NARROW_OUT: next_narrow_out = 1'b1;
          msr_pkg::CMD_WIDE_OUT: next_narrow_out = 1'b0;
          default: next_mode = msr_pkg::MSR_IDLE;
        endcase
      end else if (mode == msr_pkg::MSR_READ) begin
        events[msr_pkg::ST_CMD_ERR] = 1'b1;
      end else if (mode == msr_pkg::MSR_WRITE && cmd == msr_pkg::CMD_TRAJ_LOAD && !byte_idx[1]) begin
        // only the control word is kept; parameter bytes after it are ignored
        if (byte_idx == 2'h0) begin
          next_traj_word = {wr_data, traj_word[7:0]};
        end else begin
          next_traj_word = {traj_word[15:8], wr_data};
          next_accel_loaded = accel_loaded | wr_data[msr_pkg::TW_ACCEL_LOAD];
        end
        next_byte_idx = byte_idx + 2'h1;
      end
    end
    if (sample_tick && !(~wr_act & wr_prev & ~busy & ~wr_ps_n && wr_data == msr_pkg::CMD_FILTER_UPDATE)) begin
      next_filter_pending = 1'b0;
    end
    if (traj_finished) begin
      next_on_target = 1'b1;
    end
    if (pos_error_exceeded && stop_on_error) begin
      next_motor_off = 1'b1;
    end
    if (index_pulse && index_armed) begin
      next_index_position = actual_position;
      next_index_armed = 1'b0;
      events[msr_pkg::ST_INDEX] = 1'b1;
    end
    events[msr_pkg::ST_BREAKPOINT] = breakpoint_hit;
    events[msr_pkg::ST_POS_ERR] = pos_error_exceeded;
    events[msr_pkg::ST_WRAP] = wraparound;
    events[msr_pkg::ST_TRAJ_DONE] = done_cond & ~done_prev;
    // a new event wins over the clear in the same cycle
    if (~wr_act & wr_prev & ~busy & ~wr_ps_n && wr_data == msr_pkg::CMD_IRQ_CLEAR) begin
      next_flags = events;
      next_host_irq = |(events & irq_mask);
    end else begin
      next_flags = flags | events;
      next_host_irq = host_irq | (|(events & irq_mask));
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 12'hfff;
      sync2 <= 12'hfff;
      rd_prev <= 1'b0;
      wr_prev <= 1'b0;
      wr_ps_n <= 1'b1;
      wr_data <= msr_pkg::DOUT_RESET;
      rd_ps_n <= 1'b0;
      rd_counts <= 1'b0;
      data_out <= msr_pkg::DOUT_RESET;
      data_oe <= 1'b0;
      host_irq <= 1'b0;
      mode <= msr_pkg::MSR_IDLE;
      cmd <= msr_pkg::CMD_RESET;
      byte_idx <= 2'h0;
      busy_cnt <= 4'h0;
      traj_word <= msr_pkg::TRAJ_WORD_RESET;
      flags <= 6'h00;
      accel_loaded <= 1'b0;
      filter_pending <= 1'b0;
      forward_dir <= 1'b0;
      vel_mode <= 1'b0;
      on_target <= 1'b0;
      stop_on_error <= 1'b0;
      narrow_out <= 1'b1;
      index_armed <= 1'b0;
      done_prev <= 1'b1;
      index_position <= 32'h0000_0000;
      motor_off <= 1'b1;
    end else begin
      sync1 <= {cs_n, port_select_n, rd_n, wr_n, data_in};
      sync2 <= sync1;
      rd_prev <= rd_act;
      wr_prev <= wr_act;
      wr_ps_n <= next_wr_ps_n;
      wr_data <= next_wr_data;
      rd_ps_n <= next_rd_ps_n;
      rd_counts <= next_rd_counts;
      data_out <= next_data_out;
      data_oe <= next_data_oe;
      host_irq <= next_host_irq;
      mode <= next_mode;
      cmd <= next_cmd;
      byte_idx <= next_byte_idx;
      busy_cnt <= next_busy_cnt;
      traj_word <= next_traj_word;
      flags <= next_flags;
      accel_loaded <= next_accel_loaded;
      filter_pending <= next_filter_pending;
      forward_dir <= next_forward_dir;
      vel_mode <= next_vel_mode;
      on_target <= next_on_target;
      stop_on_error <= next_stop_on_error;
      narrow_out <= next_narrow_out;
      index_armed <= next_index_armed;
      done_prev <= next_done_prev;
      index_position <= next_index_position;
      motor_off <= next_motor_off;
    end
  end

endmodule : msr_readback

// ---- sim/msr_readback_chk.sv ----
`timescale 1ns/1ps
module msr_readback_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // host port
  input wire logic cs_n,
  input wire logic port_select_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic host_irq,
  // events and drive state
  input wire logic breakpoint_hit,
  input wire logic pos_error_exceeded,
  input wire logic [5:0] irq_mask,
  input wire logic motor_off
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // two sync flops plus the output register
  sequence s_read_held;
    (!cs_n && !rd_n)[*4];
  endsequence
  sequence s_read_idle;
    (cs_n || rd_n)[*4];
  endsequence
  // long enough for any earlier write to have acted
  sequence s_no_write;
    wr_n[*6];
  endsequence
  chk_oe_on_read: assert property (s_read_held |-> data_oe)
    else $error("bus not driven during read");
  chk_oe_off_idle: assert property (s_read_idle |-> !data_oe)
    else $error("bus driven without read");
  chk_oe_held: assert property (data_oe && !cs_n && !rd_n |=> data_oe)
    else $error("bus released during read");
  chk_out_held: assert property (s_read_idle |=> $stable(data_out))
    else $error("read buffer changed without read");
  chk_status_msb: assert property ($rose(data_oe) && !port_select_n |-> data_out[7] == $past(motor_off))
    else $error("status bit 7 differs from drive state");
  chk_irq_held: assert property (s_no_write ##0 host_irq |=> host_irq)
    else $error("interrupt dropped without clear");
  chk_irq_raise: assert property (breakpoint_hit && irq_mask[5] |-> ##[1:3] host_irq)
    else $error("unmasked event raised no interrupt");
  chk_irq_needs_mask: assert property ($rose(host_irq) |-> $past(irq_mask) != 6'h00)
    else $error("interrupt with all sources masked");
  chk_motor_steady: assert property ((wr_n && !pos_error_exceeded)[*6] |=> $stable(motor_off))
    else $error("drive state changed without cause");
endmodule : msr_readback_chk

bind msr_readback msr_readback_chk u_chk (.clk(clk), .rstn(rstn), .cs_n(cs_n), .port_select_n(port_select_n),
  .rd_n(rd_n), .wr_n(wr_n), .data_out(data_out), .data_oe(data_oe), .host_irq(host_irq),
  .breakpoint_hit(breakpoint_hit), .pos_error_exceeded(pos_error_exceeded), .irq_mask(irq_mask),
  .motor_off(motor_off));

// ---- sim/msr_host_model.sv ----
`timescale 1ns/1ps
module msr_host_model (
  // clock
  input wire logic clk,
  // host port pins
  output logic cs_n,
  output logic port_select_n,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] data_in,
  // device answer
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  int hang = 0;
  initial {cs_n, port_select_n, rd_n, wr_n, data_in} = {4'hf, 8'h00};
  // status read needs no command, any time
  task automatic rd(input logic ps, output logic [7:0] v);
    int n = 0;
    @(negedge clk);
    {cs_n, port_select_n, rd_n} <= {1'b0, ps, 1'b0};
    // sampled away from the edge that launches the answer
    do begin
      @(negedge clk);
      n++;
    end while (data_oe !== 1'b1 && n < 20);
    v = data_out;
    if (n == 20) hang++;
    @(negedge clk);
    {cs_n, rd_n} <= 2'h3;
    repeat (4) @(negedge clk);
  endtask : rd
  task automatic wr(input logic ps, input logic [7:0] v);
    @(negedge clk);
    {cs_n, port_select_n, wr_n, data_in} <= {1'b0, ps, 1'b0, v};
    repeat (3) @(negedge clk);
    {cs_n, wr_n} <= 2'h3;
    // lets this write act; busy_cnt is still 2 when the task ends
    repeat (5) @(negedge clk);
    // hold time over: inverse so a late sample shows up
    data_in <= ~v;
  endtask : wr
  task automatic ready;
    logic [7:0] s;
    int n;
    s = 8'h01;
    n = 0;
    while (s[0] !== 1'b0 && n < 10) begin
      rd(1'b0, s);
      n++;
    end
    if (s[0] !== 1'b0) hang++;
  endtask : ready
  // command port first, then data port bytes
  task automatic put(input logic ps, input logic [7:0] v);
    ready();
    wr(ps, v);
  endtask : put
  task automatic get(input logic ps, output logic [7:0] v);
    if (ps) ready();
    rd(ps, v);
  endtask : get
endmodule : msr_host_model

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic core_busy = 1'b0;
  logic cs_n, port_select_n, rd_n, wr_n, data_oe, host_irq, motor_off;
  logic [7:0] data_in, data_out, v;
  logic [5:0] ev = 6'h00;
  logic [5:0] irq_mask = 6'h00;
  logic [31:0] dpos = 32'h1234_5678;
  logic [31:0] apos = 32'h9abc_def0;
  logic [31:0] dvel = 32'hfffe_8000;
  logic [15:0] avel = 16'hfffe;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;

  always #12.5 clk = ~clk;

  msr_readback u_dut (.clk, .rstn, .cs_n, .port_select_n, .rd_n, .wr_n, .data_in, .data_out, .data_oe,
    .host_irq, .core_busy, .breakpoint_hit(ev[0]), .pos_error_exceeded(ev[1]), .wraparound(ev[2]),
    .index_pulse(ev[3]), .traj_finished(ev[4]), .sample_tick(ev[5]), .irq_mask, .desired_position(dpos),
    .actual_position(apos), .desired_velocity(dvel), .actual_velocity(avel), .motor_off);
  msr_host_model u_host (.clk, .cs_n, .port_select_n, .rd_n, .wr_n, .data_in, .data_out, .data_oe);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : check
  task automatic stat(input logic [7:0] exp);
    u_host.get(1'b0, v);
    check(v, exp);
  endtask : stat
  task automatic rdn(input logic [7:0] c, input int n, input logic [31:0] exp);
    u_host.put(1'b0, c);
    for (int i = n - 1; i >= 0; i--) begin
      u_host.get(1'b1, v);
      check(v, exp[8*i+:8]);
    end
  endtask : rdn
  task automatic hit(input int b);
    @(negedge clk);
    ev[b] = 1'b1;
    @(negedge clk);
    ev = 6'h00;
  endtask : hit
  task automatic complete_run;
    n_errors += u_host.hang;
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : complete_run

  // the sequence needs about fifteen hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    check({5'h00, data_oe, host_irq, motor_off}, 8'h01);
    u_host.put(1'b0, msr_pkg::CMD_IRQ_CLEAR);
    stat(8'h80);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h0180);
    rdn(msr_pkg::CMD_DES_POS_READ, 4, dpos);
    rdn(msr_pkg::CMD_ACT_POS_READ, 4, apos);
    rdn(msr_pkg::CMD_DES_VEL_READ, 4, dvel);
    rdn(msr_pkg::CMD_ACT_VEL_READ, 2, {16'h0000, avel});
    $display("test reset and read-backs done");
    u_host.put(1'b0, msr_pkg::CMD_SIGNALS_READ);
    core_busy = 1'b1;
    u_host.rd(1'b1, v);
    check(v, 8'h80);
    u_host.wr(1'b0, msr_pkg::CMD_START);
    u_host.wr(1'b1, 8'h55);
    stat(8'h81);
    core_busy = 1'b0;
    u_host.get(1'b1, v);
    check(v, 8'h01);
    u_host.get(1'b1, v);
    check(v, 8'h80);
    $display("test busy done");
    hit(0);
    hit(1);
    hit(2);
    stat(8'hf0);
    check({7'h00, host_irq}, 8'h00);
    irq_mask = 6'h3f;
    hit(0);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h81f0);
    u_host.put(1'b0, msr_pkg::CMD_IRQ_CLEAR);
    stat(8'h80);
    check({7'h00, host_irq}, 8'h00);
    irq_mask = 6'h00;
    u_host.put(1'b0, msr_pkg::CMD_SIGNALS_READ);
    u_host.put(1'b1, 8'h55);
    stat(8'h82);
    u_host.put(1'b0, msr_pkg::CMD_IRQ_CLEAR);
    u_host.put(1'b0, msr_pkg::CMD_TRAJ_LOAD);
    u_host.get(1'b1, v);
    stat(8'h82);
    u_host.put(1'b0, msr_pkg::CMD_IRQ_CLEAR);
    $display("test events and errors done");
    apos = 32'h0000_0123;
    u_host.put(1'b0, msr_pkg::CMD_INDEX_ARM);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h0181);
    hit(3);
    stat(8'h88);
    rdn(msr_pkg::CMD_IDX_POS_READ, 4, 32'h0000_0123);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h0188);
    u_host.put(1'b0, msr_pkg::CMD_IRQ_CLEAR);
    u_host.put(1'b0, msr_pkg::CMD_TRAJ_LOAD);
    u_host.put(1'b1, 8'h18);
    u_host.put(1'b1, 8'h00);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h0180);
    u_host.put(1'b0, msr_pkg::CMD_START);
    check({7'h00, motor_off}, 8'h00);
    hit(4);
    stat(8'h04);
    u_host.put(1'b0, msr_pkg::CMD_ERR_STOP_LOAD);
    u_host.put(1'b0, msr_pkg::CMD_WIDE_OUT);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h1e04);
    hit(1);
    check({7'h00, motor_off}, 8'h01);
    u_host.put(1'b0, msr_pkg::CMD_FILTER_UPDATE);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h3ea4);
    hit(5);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h1ea4);
    u_host.put(1'b0, msr_pkg::CMD_TRAJ_LOAD);
    u_host.put(1'b1, 8'h00);
    u_host.put(1'b1, 8'h20);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h5ea4);
    u_host.put(1'b0, msr_pkg::CMD_START);
    rdn(msr_pkg::CMD_SIGNALS_READ, 2, 32'h0224);
    $display("test index and trajectory done");
    complete_run();
  end
endmodule : tb_top
